// ===== common/rtc_pkg.sv
// Function
// - two-bit source selector picks counter clock
// - 16-bit values split into low/high bytes
// - count and limit writes apply after two ticks
// - wrap limit resets to all ones
// - match register read/write, resets to zero
// - tick interval code selects 4..32768 cycles
// - tick timer runs only while enabled
// - tick busy bit high while control synchronizes
// - tick interrupt enable bit gates tick interrupt
// - tick flag set per tick, write-one clears
// - tick timer halts in debug unless run bit
// - count busy flag high while count synchronizes
// - count wraps to zero at limit, flags wrap
// - count equal to match sets match flag
package rtc_pkg;
  localparam int SYS_CLK_HZ = 40_000_000;
  localparam int SLOW_HZ = 32_768;
  localparam int SLOW_1K_HZ = 1_024;
  localparam int INT_DIV_CYCLES = SYS_CLK_HZ / SLOW_HZ;
  localparam int K_DIV_TICKS = SLOW_HZ / SLOW_1K_HZ;
  localparam int SYNC_TICKS = 2;

  localparam logic [4:0] IDX_STATUS = 5'h01;
  localparam logic [4:0] IDX_FLAGS = 5'h03;
  localparam logic [4:0] IDX_SRC = 5'h07;
  localparam logic [4:0] IDX_CNT_LO = 5'h08;
  localparam logic [4:0] IDX_CNT_HI = 5'h09;
  localparam logic [4:0] IDX_LIM_LO = 5'h0a;
  localparam logic [4:0] IDX_LIM_HI = 5'h0b;
  localparam logic [4:0] IDX_MATCH_LO = 5'h0c;
  localparam logic [4:0] IDX_MATCH_HI = 5'h0d;
  localparam logic [4:0] IDX_TICK_CTRL = 5'h10;
  localparam logic [4:0] IDX_TICK_SYNC = 5'h11;
  localparam logic [4:0] IDX_TICK_IEN = 5'h12;
  localparam logic [4:0] IDX_TICK_FLAGS = 5'h13;
  localparam logic [4:0] IDX_TICK_HALT = 5'h15;
  localparam logic [4:0] IDX_EVT_STAT = 5'h18;
  localparam logic [4:0] IDX_EVT_MASK = 5'h19;

  localparam int SRC_LSB = 0;
  localparam int TICK_EN_BIT = 0;
  localparam int TICK_PER_LSB = 3;
  localparam int TICK_PER_MSB = 6;
  localparam int BUSY_CNT_BIT = 1;
  localparam int BUSY_LIM_BIT = 2;
  localparam int FLAG_WRAP_BIT = 0;
  localparam int FLAG_MATCH_BIT = 1;
  localparam int EVT_TICK_BIT = 2;

  localparam logic [1:0] SRC_INT32K = 2'h0;
  localparam logic [1:0] SRC_INT1K = 2'h1;
  localparam logic [1:0] SRC_XTAL32K = 2'h2;
  localparam logic [1:0] SRC_EXT_PIN = 2'h3;
  localparam logic [3:0] TICK_PER_OFF = 4'h0;
  localparam logic [3:0] TICK_PER_RSVD = 4'hf;

  localparam logic [1:0] SRC_RESET = 2'h0;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] LIMIT_RESET = 16'hffff;
  localparam logic [15:0] MATCH_RESET = 16'h0000;
  localparam logic [6:0] TICK_CTRL_RESET = 7'h00;

  typedef enum logic [2:0] {
    SYNC_IDLE = 3'b001,
    SYNC_ONE = 3'b010,
    SYNC_TWO = 3'b100
  } rtc_sync_e;
endpackage

// ===== core/rtc_core.sv
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
module rtc_core #(
  parameter int DIV_CYCLES = rtc_pkg::INT_DIV_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic [6:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_crystal_clk,
  input wire logic i_ext_pin_clk,
  input wire logic i_dbg_halt,
  output logic o_tick_irq,
  output logic o_irq
);
  import rtc_pkg::*;

  if (DIV_CYCLES < 2 || DIV_CYCLES > 2047) begin : g_bad_div
    $error("DIV_CYCLES must lie in 2..2047");
  end

  // bus slave: one wait state, access completes on ack_q
  logic ack_q;
  logic [31:0] rdata_q;
  logic [4:0] idx;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;

  assign idx = i_avs_address[6:2];
  assign wbyte = i_avs_writedata[7:0];
  assign wr_fire = i_avs_write & ack_q & i_avs_byteenable[0];
  assign rd_fire = i_avs_read & ack_q;
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
  assign o_avs_readdata = rdata_q;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
    end
  end

  // slow clock sources
  logic [10:0] int_div_q;
  logic [4:0] k_div_q;
  logic [2:0] xtal_s_q;
  logic [2:0] ext_s_q;
  logic int32_tick;
  logic int1k_tick;
  logic slow_tick;
  logic [1:0] src_q;

  assign int32_tick = (int_div_q == 11'(DIV_CYCLES - 1));
  assign int1k_tick = int32_tick & (k_div_q == 5'(K_DIV_TICKS - 1));

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      int_div_q <= 11'h000;
      k_div_q <= 5'h00;
    end else begin
      int_div_q <= int32_tick ? 11'h000 : int_div_q + 11'h001;
      if (int32_tick) begin
        k_div_q <= k_div_q + 5'h01;
      end
    end
  end

  // pin clocks pass two flops, the third is for edge detection
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      xtal_s_q <= 3'h0;
      ext_s_q <= 3'h0;
    end else begin
      xtal_s_q <= {xtal_s_q[1:0], i_crystal_clk};
      ext_s_q <= {ext_s_q[1:0], i_ext_pin_clk};
    end
  end

  always_comb begin
    case (src_q)
      SRC_INT32K: slow_tick = int32_tick;
      SRC_INT1K: slow_tick = int1k_tick;
      SRC_XTAL32K: slow_tick = xtal_s_q[1] & ~xtal_s_q[2];
      SRC_EXT_PIN: slow_tick = ext_s_q[1] & ~ext_s_q[2];
      default: slow_tick = 1'b0;
    endcase
  end

  // synchronizers into the slow domain: 0 count, 1 limit, 2 tick control
  logic [2:0] sync_wr;
  logic [2:0] sync_busy;
  logic [2:0] sync_apply;

  assign sync_wr[0] = wr_fire & (idx == IDX_CNT_LO || idx == IDX_CNT_HI);
  assign sync_wr[1] = wr_fire & (idx == IDX_LIM_LO || idx == IDX_LIM_HI);
  assign sync_wr[2] = wr_fire & (idx == IDX_TICK_CTRL);

  for (genvar g = 0; g < 3; g++) begin : g_sync
    rtc_sync_e st_q;
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
        st_q <= SYNC_IDLE;
      end else if (sync_wr[g]) begin
        st_q <= SYNC_ONE;
      end else if (slow_tick) begin
        case (st_q)
          SYNC_ONE: st_q <= SYNC_TWO;
          SYNC_TWO: st_q <= SYNC_IDLE;
          SYNC_IDLE: st_q <= SYNC_IDLE;
          default: st_q <= SYNC_IDLE;
        endcase
      end
    end
    assign sync_busy[g] = (st_q != SYNC_IDLE);
    assign sync_apply[g] = (st_q == SYNC_TWO) & slow_tick & ~sync_wr[g];
  end

  // registers
  logic [15:0] count_q;
  logic [15:0] cnt_shadow_q;
  logic [15:0] limit_q;
  logic [15:0] lim_shadow_q;
  logic [15:0] match_q;
  logic [6:0] tick_ctrl_q;
  logic [6:0] tick_shadow_q;
  logic tick_ien_q;
  logic run_when_halted_q;
  logic [2:0] evt_mask_q;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      src_q <= SRC_RESET;
      match_q <= MATCH_RESET;
      tick_ien_q <= 1'b0;
      run_when_halted_q <= 1'b0;
      evt_mask_q <= 3'h0;
    end else if (wr_fire) begin
      case (idx)
        IDX_SRC: src_q <= wbyte[SRC_LSB +: 2];
        IDX_MATCH_LO: match_q[7:0] <= wbyte;
        IDX_MATCH_HI: match_q[15:8] <= wbyte;
        IDX_TICK_IEN: tick_ien_q <= wbyte[0];
        IDX_TICK_HALT: run_when_halted_q <= wbyte[0];
        IDX_EVT_MASK: evt_mask_q <= wbyte[2:0];
        default: src_q <= src_q;
      endcase
    end
  end

  // shadows hold written values until the slow domain takes them
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_shadow_q <= COUNT_RESET;
      lim_shadow_q <= LIMIT_RESET;
      tick_shadow_q <= TICK_CTRL_RESET;
    end else if (wr_fire) begin
      case (idx)
        IDX_CNT_LO: cnt_shadow_q <= {sync_busy[0] ? cnt_shadow_q[15:8] : count_q[15:8], wbyte};
        IDX_CNT_HI: cnt_shadow_q <= {wbyte, sync_busy[0] ? cnt_shadow_q[7:0] : count_q[7:0]};
        IDX_LIM_LO: lim_shadow_q[7:0] <= wbyte;
        IDX_LIM_HI: lim_shadow_q[15:8] <= wbyte;
        IDX_TICK_CTRL: tick_shadow_q <= wbyte[6:0];
        default: tick_shadow_q <= tick_shadow_q;
      endcase
    end
  end

  // counter in the slow domain
  logic wrap_hit;
  logic match_hit;

  assign wrap_hit = slow_tick & ~sync_apply[0] & (count_q == limit_q);
  assign match_hit = slow_tick & (count_q == match_q);

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      count_q <= COUNT_RESET;
    end else if (sync_apply[0]) begin
      count_q <= cnt_shadow_q;
    end else if (wrap_hit) begin
      count_q <= 16'h0000;
    end else if (slow_tick) begin
      count_q <= count_q + 16'h0001;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      limit_q <= LIMIT_RESET;
      tick_ctrl_q <= TICK_CTRL_RESET;
    end else begin
      if (sync_apply[1]) begin
        limit_q <= lim_shadow_q;
      end
      if (sync_apply[2]) begin
        tick_ctrl_q <= tick_shadow_q;
      end
    end
  end

  // periodic tick timer
  logic [3:0] tick_per;
  logic tick_en;
  logic pit_run;
  logic pit_tick;
  logic [14:0] pit_cnt_q;
  logic [14:0] pit_mask;

  assign tick_per = tick_ctrl_q[TICK_PER_MSB:TICK_PER_LSB];
  assign tick_en = tick_ctrl_q[TICK_EN_BIT];
  assign pit_run = tick_en & ~(i_dbg_halt & ~run_when_halted_q);

  always_comb begin
    for (int i = 0; i < 15; i++) begin
      pit_mask[i] = (i <= int'(tick_per));
    end
  end

  assign pit_tick = slow_tick & pit_run & (tick_per != TICK_PER_OFF) & (tick_per != TICK_PER_RSVD)
                    & ((pit_cnt_q & pit_mask) == pit_mask);

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pit_cnt_q <= 15'h0000;
    end else if (!tick_en) begin
      pit_cnt_q <= 15'h0000;
    end else if (slow_tick & pit_run) begin
      pit_cnt_q <= pit_cnt_q + 15'h0001;
    end
  end

  // flags: hardware set wins over a same-cycle clear
  logic [1:0] flags_q;
  logic tick_flag_q;
  logic [2:0] evt_q;
  logic [2:0] evt_hit;
  logic evt_rd;

  assign evt_hit = {pit_tick, match_hit, wrap_hit};
  assign evt_rd = rd_fire & (idx == IDX_EVT_STAT);

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      flags_q <= 2'h0;
      tick_flag_q <= 1'b0;
      evt_q <= 3'h0;
    end else begin
      flags_q[FLAG_WRAP_BIT] <= wrap_hit |
        (flags_q[FLAG_WRAP_BIT] & ~(wr_fire & idx == IDX_FLAGS & wbyte[FLAG_WRAP_BIT]));
      flags_q[FLAG_MATCH_BIT] <= match_hit |
        (flags_q[FLAG_MATCH_BIT] & ~(wr_fire & idx == IDX_FLAGS & wbyte[FLAG_MATCH_BIT]));
      tick_flag_q <= pit_tick | (tick_flag_q & ~(wr_fire & idx == IDX_TICK_FLAGS & wbyte[0]));
      // read clears only the bits it reported, so an event landing in the wait cycle survives
      evt_q <= evt_hit | (evt_q & ~({3{evt_rd}} & rdata_q[2:0]));
    end
  end

  assign o_tick_irq = tick_flag_q & tick_ien_q;
  assign o_irq = |(evt_q & evt_mask_q);

  // read data, captured in the wait cycle
  always_comb begin
    case (idx)
      IDX_STATUS: rd_byte = {5'h00, sync_busy[1], sync_busy[0], 1'b0};
      IDX_FLAGS: rd_byte = {6'h00, flags_q};
      IDX_SRC: rd_byte = {6'h00, src_q};
      IDX_CNT_LO: rd_byte = count_q[7:0];
      IDX_CNT_HI: rd_byte = count_q[15:8];
      IDX_LIM_LO: rd_byte = lim_shadow_q[7:0];
      IDX_LIM_HI: rd_byte = lim_shadow_q[15:8];
      IDX_MATCH_LO: rd_byte = match_q[7:0];
      IDX_MATCH_HI: rd_byte = match_q[15:8];
      IDX_TICK_CTRL: rd_byte = {1'b0, tick_shadow_q};
      IDX_TICK_SYNC: rd_byte = {7'h00, sync_busy[2]};
      IDX_TICK_IEN: rd_byte = {7'h00, tick_ien_q};
      IDX_TICK_FLAGS: rd_byte = {7'h00, tick_flag_q};
      IDX_TICK_HALT: rd_byte = {7'h00, run_when_halted_q};
      IDX_EVT_STAT: rd_byte = {5'h00, evt_q};
      IDX_EVT_MASK: rd_byte = {5'h00, evt_mask_q};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_avs_read & ~ack_q) begin
      rdata_q <= {24'h00_0000, rd_byte};
    end
  end

  a_cnt_busy_set: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    sync_wr[0] |=> sync_busy[0] && g_sync[0].st_q == SYNC_ONE)
    else $error("count busy not set after count write");

  a_cnt_apply_val: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    sync_apply[0] |=> count_q == $past(cnt_shadow_q) && !sync_busy[0])
    else $error("count shadow not applied");

  a_apply_two_ticks: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    $fell(sync_busy[1]) |-> $past(slow_tick) && $past(g_sync[1].st_q) == SYNC_TWO)
    else $error("limit applied without two slow ticks");

  a_tick_busy_read: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_avs_read && idx == IDX_TICK_SYNC && !ack_q && sync_busy[2]) |=> rdata_q[0])
    else $error("tick busy not visible on read");

  a_wrap_to_zero: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    wrap_hit |=> count_q == 16'h0000 && flags_q[FLAG_WRAP_BIT])
    else $error("counter did not wrap at limit");

  a_match_flag: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    match_hit |=> flags_q[FLAG_MATCH_BIT] && evt_q[FLAG_MATCH_BIT])
    else $error("match flag not set");

  a_tick_off_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (!tick_en || tick_per == TICK_PER_OFF || tick_per == TICK_PER_RSVD) |-> !pit_tick)
    else $error("tick while disabled");

  a_tick_halted: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_dbg_halt && !run_when_halted_q) |=> pit_cnt_q == $past(pit_cnt_q) || !tick_en)
    else $error("tick timer ran while halted");

  a_tick_flag_set: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    pit_tick |=> tick_flag_q ##0 (o_tick_irq == tick_ien_q))
    else $error("tick flag or irq wrong after tick");

  a_tick_interval: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (pit_tick && tick_per == 4'h1) |-> pit_cnt_q[1:0] == 2'h3)
    else $error("tick interval code one not four cycles");

  a_evt_read_keep: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (evt_rd && evt_q[EVT_TICK_BIT] && !rdata_q[EVT_TICK_BIT]) |=> evt_q[EVT_TICK_BIT])
    else $error("unreported tick event lost on read");
endmodule

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
  import rtc_pkg::*;
  localparam int DIV = 8;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [6:0] addr = 7'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'h0;
  logic [31:0] rdata;
  logic waitreq;
  logic xtal = 1'b0;
  logic ext = 1'b0;
  logic halt = 1'b0;
  logic tick_irq;
  logic irq;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [15:0] v;
  logic [7:0] b;
  logic [7:0] a;
  int t0;
  int t1;

  rtc_core #(.DIV_CYCLES(DIV)) u_rtc_core (.i_sys_clk(clk), .i_nrst(nrst), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .i_crystal_clk(xtal), .i_ext_pin_clk(ext), .i_dbg_halt(halt),
    .o_tick_irq(tick_irq), .o_irq(irq));

  always #12.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one avalon access; request held until waitrequest is seen low at a rising edge
  task automatic acc(input logic is_wr, input logic [4:0] idx, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    q = 8'h00;
    @(posedge clk);
    addr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    be <= 4'hf;
    rd <= !is_wr;
    wr <= is_wr;
    @(posedge clk);
    while (waitreq !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (waitreq !== 1'b0) chk(16'h0bad, 16'h0000);
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wr8(input logic [4:0] idx, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, idx, d, q);
  endtask

  task automatic rd8(input logic [4:0] idx, output logic [7:0] q);
    acc(1'b0, idx, 8'h00, q);
  endtask

  task automatic wr16(input logic [4:0] idx, input logic [15:0] d);
    wr8(idx, d[7:0]);
    wr8(idx + 5'h01, d[15:8]);
  endtask

  task automatic rd16(input logic [4:0] idx, output logic [15:0] q);
    rd8(idx, q[7:0]);
    rd8(idx + 5'h01, q[15:8]);
  endtask

  task automatic wait_clr(input logic [4:0] idx, input int bitn);
    logic [7:0] q;
    int n;
    n = 0;
    q = 8'hff;
    while (q[bitn] !== 1'b0 && n < 100) begin
      rd8(idx, q);
      n++;
    end
    chk(q[bitn], 1'b0);
  endtask

  task automatic wait_irq(output int t);
    int n;
    t = -1;
    for (n = 0; n < 2000 && t < 0; n++) begin
      @(posedge clk);
      #1;
      if (tick_irq === 1'b1) t = cyc;
    end
    if (t < 0) chk(16'h0bad, 16'h0001);
  endtask

  task automatic pulses(input logic use_ext, input int n);
    repeat (n) begin
      @(posedge clk);
      if (use_ext) ext <= 1'b1; else xtal <= 1'b1;
      repeat (6) @(posedge clk);
      if (use_ext) ext <= 1'b0; else xtal <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    test_done();
  end

  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rd16(IDX_LIM_LO, v); chk(v, 16'hffff);
    rd16(IDX_MATCH_LO, v); chk(v, 16'h0000);
    rd8(IDX_SRC, b); chk(b, 8'h00);
    rd8(IDX_TICK_SYNC, b); chk(b, 8'h00);
    @(negedge clk);
    chk({tick_irq, irq}, 2'b00);
    $display("reset test done");
    wr16(IDX_MATCH_LO, 16'h1234);
    rd16(IDX_MATCH_LO, v); chk(v, 16'h1234);
    wr16(IDX_LIM_LO, 16'h0003);
    rd8(IDX_STATUS, b); chk(b[BUSY_LIM_BIT], 1'b1);
    wait_clr(IDX_STATUS, BUSY_LIM_BIT);
    rd16(IDX_LIM_LO, v); chk(v, 16'h0003);
    wr16(IDX_CNT_LO, 16'h0000);
    wait_clr(IDX_STATUS, BUSY_CNT_BIT);
    wr8(IDX_FLAGS, 8'h03);
    repeat (100) @(posedge clk);
    rd8(IDX_FLAGS, b); chk(b[FLAG_WRAP_BIT], 1'b1);
    rd16(IDX_CNT_LO, v); chk(v <= 16'h0003, 1'b1);
    wr16(IDX_LIM_LO, 16'hffff);
    wait_clr(IDX_STATUS, BUSY_LIM_BIT);
    wr16(IDX_CNT_LO, 16'h0100);
    rd8(IDX_STATUS, b); chk(b[BUSY_CNT_BIT], 1'b1);
    wait_clr(IDX_STATUS, BUSY_CNT_BIT);
    rd16(IDX_CNT_LO, v); chk(v[15:8], 8'h01);
    wr8(IDX_FLAGS, 8'h03);
    rd8(IDX_FLAGS, b); chk(b, 8'h00);
    wr16(IDX_MATCH_LO, 16'h0110);
    repeat (300) @(posedge clk);
    rd8(IDX_FLAGS, b); chk(b, 8'h02);
    $display("counter test done");
    for (int s = 0; s < 4; s++) begin
      wr8(IDX_SRC, 8'(s));
      rd8(IDX_SRC, b); chk(b, 8'(s));
    end
    rd8(IDX_CNT_LO, a);
    repeat (60) @(posedge clk);
    rd8(IDX_CNT_LO, b); chk(b, a);
    pulses(1'b1, 5);
    rd8(IDX_CNT_LO, b); chk(b, a + 8'h05);
    wr8(IDX_SRC, 8'h02);
    rd8(IDX_CNT_LO, a);
    pulses(1'b0, 3);
    rd8(IDX_CNT_LO, b); chk(b, a + 8'h03);
    wr8(IDX_SRC, 8'h01);
    rd8(IDX_CNT_LO, a);
    repeat (32 * DIV * 4) @(posedge clk);
    rd8(IDX_CNT_LO, b); chk(b - a >= 8'h03 && b - a <= 8'h05, 1'b1);
    wr8(IDX_SRC, 8'h00);
    $display("source test done");
    wr8(IDX_TICK_IEN, 8'h01);
    wr8(IDX_TICK_CTRL, 8'h09);
    rd8(IDX_TICK_SYNC, b); chk(b, 8'h01);
    wait_clr(IDX_TICK_SYNC, 0);
    for (int c = 1; c < 4; c++) begin
      wr8(IDX_TICK_CTRL, 8'((c << 3) | 1));
      wait_clr(IDX_TICK_SYNC, 0);
      wait_irq(t0);
      rd8(IDX_TICK_FLAGS, b); chk(b, 8'h01);
      wr8(IDX_TICK_FLAGS, 8'h01);
      wait_irq(t0);
      wr8(IDX_TICK_FLAGS, 8'h01);
      wait_irq(t1);
      chk(16'(t1 - t0), 16'((2 ** (c + 1)) * DIV));
    end
    wr8(IDX_TICK_CTRL, 8'h01);
    wait_clr(IDX_TICK_SYNC, 0);
    wr8(IDX_TICK_FLAGS, 8'h01);
    repeat (300) @(posedge clk);
    rd8(IDX_TICK_FLAGS, b); chk(b, 8'h00);
    wr8(IDX_TICK_CTRL, 8'h09);
    wait_clr(IDX_TICK_SYNC, 0);
    wr8(IDX_TICK_IEN, 8'h00);
    repeat (100) @(posedge clk);
    rd8(IDX_TICK_FLAGS, b); chk(b, 8'h01);
    @(negedge clk);
    chk(tick_irq, 1'b0);
    wr8(IDX_TICK_IEN, 8'h01);
    @(negedge clk);
    chk(tick_irq, 1'b1);
    wr8(IDX_TICK_CTRL, 8'h08);
    wait_clr(IDX_TICK_SYNC, 0);
    wr8(IDX_TICK_FLAGS, 8'h01);
    repeat (200) @(posedge clk);
    rd8(IDX_TICK_FLAGS, b); chk(b, 8'h00);
    wr8(IDX_TICK_CTRL, 8'h09);
    wait_clr(IDX_TICK_SYNC, 0);
    halt <= 1'b1;
    wr8(IDX_TICK_FLAGS, 8'h01);
    repeat (200) @(posedge clk);
    rd8(IDX_TICK_FLAGS, b); chk(b, 8'h00);
    wr8(IDX_TICK_HALT, 8'h01);
    wait_irq(t0); chk(tick_irq, 1'b1);
    halt <= 1'b0;
    $display("tick test done");
    wr8(IDX_EVT_MASK, 8'h04);
    @(negedge clk);
    chk(irq, 1'b1);
    wr8(IDX_TICK_CTRL, 8'h00);
    wait_clr(IDX_TICK_SYNC, 0);
    rd8(IDX_EVT_STAT, b); chk(b[EVT_TICK_BIT], 1'b1);
    rd8(IDX_EVT_STAT, b); chk(b[EVT_TICK_BIT], 1'b0);
    @(negedge clk);
    chk(irq, 1'b0);
    $display("event test done");
    @(posedge clk);
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rd16(IDX_LIM_LO, v); chk(v, 16'hffff);
    rd16(IDX_MATCH_LO, v); chk(v, 16'h0000);
    rd8(IDX_TICK_CTRL, b); chk(b, 8'h00);
    @(negedge clk);
    chk({tick_irq, irq}, 2'b00);
    $display("second reset test done");
    test_done();
  end
endmodule
